// ### include/pbc_pkg.sv
// Purpose: shared constants, types and decode for the processor board config block
// Assumes: switch bit on / jumper right reads as 1 on the pins
// Notes: What this block does
// What this block does
// - three switch bits select processor clock
// - one-hot wait bits give 3 to 6 cycles
// - size select picks 1 MByte or 256 KByte
// - processor control from host or up port
// - slot control from subsystem or processor source
// - reset copy bit forwards processor reset to subsystem
// - two bits pick host base or disable
// - three bits set processor link speeds
// - link 0 routed to host or D-type
// - two bits pick DMA channel or none
// - one bit picks IRQ 3 or 6
package pbc_pkg;
  // switch bank bit positions
  localparam int SW1_DMA_A = 0;
  localparam int SW1_DMA_B = 1;
  localparam int SW1_IRQ3 = 2;
  localparam int SW1_BASE_A = 3;
  localparam int SW1_BASE_B = 4;
  localparam int SW1_HOST_RATE = 5;
  localparam int SW1_SLOT_RATE = 6;
  localparam int SW1_RST_COPY = 7;
  localparam int SW2_SLOW = 0;
  localparam int SW2_L0 = 1;
  localparam int SW2_L123 = 2;
  localparam int SW2_CLK_LSB = 3;
  // clock select codes {sw2.6, sw2.5, sw2.4}
  localparam logic [2:0] CLK_SEL_17M5 = 3'h1;
  localparam logic [2:0] CLK_SEL_20M = 3'h7;
  localparam logic [2:0] CLK_SEL_25M = 3'h5;
  localparam logic [2:0] CLK_SEL_30M = 3'h4;
  // memory access cycle counts
  localparam logic [2:0] WAIT_CYC_3 = 3'h3;
  localparam logic [2:0] WAIT_CYC_4 = 3'h4;
  localparam logic [2:0] WAIT_CYC_5 = 3'h5;
  localparam logic [2:0] WAIT_CYC_6 = 3'h6;
  // host i/o bases, 16-byte window
  localparam logic [9:0] HOST_BASE_150 = 10'h150;
  localparam logic [9:0] HOST_BASE_200 = 10'h200;
  localparam logic [9:0] HOST_BASE_300 = 10'h300;
  localparam int HOST_WIN_LSB = 4;
  // memory address fields
  localparam int MEM_BANK_LSB_1M = 22;
  localparam int MEM_BANK_LSB_256K = 20;
  // apb map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CFG = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_ANALYSE_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] CFG_SETTLE = 2'h2;
  localparam logic [7:0] SW1_RST = 8'h96;
  localparam logic [5:0] SW2_RST = 6'h38;
  localparam logic [3:0] SW3_RST = 4'h4;

  typedef enum logic [1:0] {CLK_17M5, CLK_20M, CLK_25M, CLK_30M} pbc_cpu_clk_type;
  typedef enum logic [1:0] {RATE_5M, RATE_10M, RATE_20M} pbc_rate_type;
  typedef enum logic [1:0] {DMA_OFF, DMA_CH1, DMA_CH2} pbc_dma_type;

  typedef struct packed {
    logic [7:0] host_config_switch_bank;
    logic [5:0] cpu_clock_link_switch_bank;
    logic [3:0] wait_state_select;
    logic link0_route_select;
    logic cpu_control_source_select;
    logic module_size_select;
    logic slot_control_source_select;
  } pbc_cfg_pins_type;

  typedef struct packed {
    logic up_reset;
    logic up_analyse;
    logic subsys_reset;
    logic subsys_analyse;
    logic cpu_error;
    logic slot_error;
    logic host_irq_req;
    logic dma_req;
  } pbc_ctl_pins_type;

  typedef struct packed {
    pbc_cpu_clk_type cpu_clk;
    logic [2:0] wait_cycles;
    logic mem_1mb;
    logic cpu_ctl_edge;
    logic slot_ctl_same;
    logic reset_copy;
    logic host_en;
    logic [9:0] host_base;
    pbc_rate_type host_link_rate;
    pbc_rate_type slot_link_rate;
    pbc_rate_type cpu_link0_rate;
    pbc_rate_type cpu_link123_rate;
    logic link0_to_dtype;
    pbc_dma_type dma;
    logic irq3;
  } pbc_cfg_type;

  typedef struct packed {
    logic loaded;
    logic [1:0] settle;
    pbc_cfg_type cfg;
    logic [1:0] ctrl;
    logic cpu_reset;
    logic cpu_analyse;
    logic slot_reset;
    logic slot_analyse;
    logic up_error;
    logic subsys_error;
    logic host_error;
    logic host_io_sel;
    logic irq3;
    logic irq6;
    logic dma1;
    logic dma2;
    logic [1:0] mem_bank;
    logic [19:0] mem_word;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pbc_state_type;

  function automatic pbc_cfg_type pbc_decode(input pbc_cfg_pins_type p);
    pbc_cfg_type c;
    logic [7:0] s1;
    logic [5:0] s2;
    logic [2:0] ck;
    c = '0;
    s1 = p.host_config_switch_bank;
    s2 = p.cpu_clock_link_switch_bank;
    ck = s2[SW2_CLK_LSB +: 3];
    case (ck)
      CLK_SEL_17M5: c.cpu_clk = CLK_17M5;
      CLK_SEL_25M: c.cpu_clk = CLK_25M;
      CLK_SEL_30M: c.cpu_clk = CLK_30M;
      default: c.cpu_clk = CLK_20M;
    endcase
    if (p.wait_state_select[0])
      c.wait_cycles = WAIT_CYC_3;
    else if (p.wait_state_select[1])
      c.wait_cycles = WAIT_CYC_4;
    else if (p.wait_state_select[3])
      c.wait_cycles = WAIT_CYC_6;
    else
      c.wait_cycles = WAIT_CYC_5;
    c.mem_1mb = !p.module_size_select;
    c.cpu_ctl_edge = p.cpu_control_source_select;
    c.slot_ctl_same = p.slot_control_source_select;
    c.reset_copy = s1[SW1_RST_COPY];
    c.host_en = 1'b1;
    case ({s1[SW1_BASE_A], s1[SW1_BASE_B]})
      2'b01: c.host_base = HOST_BASE_150;
      2'b10: c.host_base = HOST_BASE_200;
      2'b00: c.host_base = HOST_BASE_300;
      default: c.host_en = 1'b0;
    endcase
    c.host_link_rate = s1[SW1_HOST_RATE] ? RATE_10M : RATE_20M;
    c.slot_link_rate = s1[SW1_SLOT_RATE] ? RATE_10M : RATE_20M;
    c.cpu_link0_rate = s2[SW2_L0] ? RATE_10M : (s2[SW2_SLOW] ? RATE_5M : RATE_20M);
    c.cpu_link123_rate = s2[SW2_L123] ? RATE_10M : (s2[SW2_SLOW] ? RATE_5M : RATE_20M);
    c.link0_to_dtype = p.link0_route_select;
    case ({s1[SW1_DMA_A], s1[SW1_DMA_B]})
      2'b01: c.dma = DMA_CH1;
      2'b10: c.dma = DMA_CH2;
      default: c.dma = DMA_OFF;
    endcase
    c.irq3 = s1[SW1_IRQ3];
    return c;
  endfunction

  localparam pbc_cfg_pins_type PINS_RST = '{host_config_switch_bank: SW1_RST,
    cpu_clock_link_switch_bank: SW2_RST, wait_state_select: SW3_RST, link0_route_select: 1'b0,
    cpu_control_source_select: 1'b0, module_size_select: 1'b0, slot_control_source_select: 1'b0};
  localparam pbc_cfg_type CFG_RST = pbc_decode(PINS_RST);
endpackage

// ### test/pbc_edge_model.sv
// Purpose: host bus and edge connector side of the config block
// Assumes: pin levels change just after a rising edge
// Notes: keeps the switch setting self-consistent
`timescale 1ns/1ps
module pbc_edge_model
  import pbc_pkg::*;
(
  // clock
  input wire logic clock_in,
  // requested setting
  input wire pbc_cfg_pins_type set_in,
  input wire logic [1:0] wait_idx_in,
  input wire pbc_ctl_pins_type ctl_in,
  input wire logic [9:0] addr_in,
  // board pins
  output pbc_cfg_pins_type cfg_pins_out,
  output pbc_ctl_pins_type ctl_pins_out,
  output logic [9:0] host_io_addr_out
);
  always_ff @(posedge clock_in)
  begin
    // one wait bit only, picked by wait_idx_in
    cfg_pins_out <= {set_in[21:8], 4'h1 << wait_idx_in, set_in[3:0]};
    ctl_pins_out <= ctl_in;
    host_io_addr_out <= addr_in;
  end
endmodule

// ### test/tb_pbc_config_decoder.sv
// Purpose: self-checking bench for the board config decoder
// Assumes: edge model drives switch and control pins
// Notes: each setting is loaded by a board reset
`timescale 1ns/1ps
module tb_pbc_config_decoder
  import pbc_pkg::*;
;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mreq = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, mem_busy_out, mem_done_out;
  logic [23:0] maddr = '0;
  logic [1:0] bank_out;
  logic [19:0] word_out;
  logic [1:0] widx = 2'h2;
  logic [9:0] hadr = '0, hpin;
  pbc_cfg_pins_type set_pins = PINS_RST, cfg_pins;
  pbc_ctl_pins_type ctl = '0, ctl_pins;
  pbc_cfg_type cfg_out;
  logic [10:0] lv_out;
  logic [65:0] nt;
  logic [65:0] notes_q[$];
  int failures = 0, tests_run = 0, seed = 93707;

  initial
  begin
    forever #10 clock_in = ~clock_in;
  end

  pbc_edge_model u_pbc_edge_model (.clock_in(clock_in), .set_in(set_pins), .wait_idx_in(widx), .ctl_in(ctl),
    .addr_in(hadr), .cfg_pins_out(cfg_pins), .ctl_pins_out(ctl_pins), .host_io_addr_out(hpin));

  pbc_config_decoder u_pbc_config_decoder (.clock_in(clock_in), .nrst_in(nrst_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .cfg_pins_in(cfg_pins),
    .ctl_pins_in(ctl_pins), .host_io_addr_in(hpin), .mem_req_in(mreq), .mem_addr_in(maddr),
    .mem_busy_out(mem_busy_out), .mem_done_out(mem_done_out), .mem_bank_out(bank_out),
    .mem_word_out(word_out), .cfg_out(cfg_out), .cpu_reset_out(lv_out[10]), .cpu_analyse_out(lv_out[9]),
    .slot_reset_out(lv_out[8]), .slot_analyse_out(lv_out[7]), .up_error_out(lv_out[6]),
    .subsys_error_out(lv_out[5]), .host_io_sel_out(lv_out[4]), .host_irq3_out(lv_out[3]),
    .host_irq6_out(lv_out[2]), .host_dma1_req_out(lv_out[1]), .host_dma2_req_out(lv_out[0]));

  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic pbc_cfg_type want(input pbc_cfg_pins_type p, input logic [1:0] wi);
    pbc_cfg_type c;
    logic [7:0] a;
    logic [5:0] b;
    a = p.host_config_switch_bank;
    b = p.cpu_clock_link_switch_bank;
    c = '0;
    case (b[5:3])
      3'h1: c.cpu_clk = CLK_17M5;
      3'h5: c.cpu_clk = CLK_25M;
      3'h4: c.cpu_clk = CLK_30M;
      default: c.cpu_clk = CLK_20M;
    endcase
    c.wait_cycles = 3'h3 + 3'(wi);
    c.mem_1mb = !p.module_size_select;
    c.cpu_ctl_edge = p.cpu_control_source_select;
    c.slot_ctl_same = p.slot_control_source_select;
    c.reset_copy = a[7];
    c.host_en = !(a[3] & a[4]);
    c.host_base = a[3] ? (a[4] ? 10'h000 : 10'h200) : (a[4] ? 10'h150 : 10'h300);
    c.host_link_rate = a[5] ? RATE_10M : RATE_20M;
    c.slot_link_rate = a[6] ? RATE_10M : RATE_20M;
    c.cpu_link0_rate = b[1] ? RATE_10M : (b[0] ? RATE_5M : RATE_20M);
    c.cpu_link123_rate = b[2] ? RATE_10M : (b[0] ? RATE_5M : RATE_20M);
    c.link0_to_dtype = p.link0_route_select;
    c.dma = (a[0] ^ a[1]) ? (a[1] ? DMA_CH1 : DMA_CH2) : DMA_OFF;
    c.irq3 = a[2];
    return c;
  endfunction

  // apb master, answer noted for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [65:0] n);
    notes_q.push_back(n);
    @(posedge clock_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1)
      @(posedge clock_in);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  always @(posedge clock_in)
    if (pready_out === 1'b1)
    begin
      nt = notes_q.size() == 0 ? '1 : notes_q.pop_front();
      chk(64'(nt[65:33] & {pslverr_out, prdata_out}), 64'(nt[65:33] & nt[32:0]));
    end

  task automatic load(input pbc_cfg_pins_type sw, input logic [1:0] wi);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    set_pins <= sw;
    widx <= wi;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (5) @(posedge clock_in);
  endtask

  // request held two cycles: the second sample falls while busy
  task automatic mem_go(input logic [23:0] a, input logic [2:0] n, input logic big);
    int k;
    @(posedge clock_in);
    mreq <= 1'b1;
    maddr <= a;
    repeat (2) @(posedge clock_in);
    mreq <= 1'b0;
    k = 1;
    while (mem_done_out !== 1'b1)
    begin
      @(posedge clock_in);
      k++;
    end
    chk(64'(k), 64'(n));
    chk({bank_out, word_out}, big ? {a[23:22], a[21:2]} : {a[21:20], 2'b00, a[19:2]});
    @(posedge clock_in);
    chk(mem_busy_out, 1'b0);
  endtask

  initial
  begin
    #300000;
    failures++;
    wrap_up();
  end

  initial
  begin
    pbc_cfg_pins_type sw;
    pbc_ctl_pins_type cp;
    pbc_cfg_type e;
    logic [31:0] r;
    logic [11:0] ckt;
    logic [9:0] ha;
    logic cr, ca, herr;
    ckt = {3'h4, 3'h5, 3'h7, 3'h1};
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    chk(64'(cfg_out), 64'h6cd5_0aa3);
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      sw = pbc_cfg_pins_type'(r[21:0]);
      sw.host_config_switch_bank[4:3] = i[1:0];
      sw.host_config_switch_bank[1:0] = i[2:1];
      sw.cpu_clock_link_switch_bank[5:3] = ckt[3 * i[3:2] +: 3];
      load(sw, r[23:22]);
      e = want(sw, r[23:22]);
      chk(64'(cfg_out), 64'(e));
      apb(1'b1, REG_CFG, r, {33'h1_0000_0000, 33'h0});
      apb(1'b0, REG_CFG, 32'h0, {33'h1_ffff_ffff, 1'b0, e});
      mem_go(24'($random(seed)), e.wait_cycles, e.mem_1mb);
      cp = pbc_ctl_pins_type'(8'($random(seed)));
      ha = i[0] ? (e.host_base | 10'(r[27:24])) : r[31:22];
      @(posedge clock_in);
      set_pins <= pbc_cfg_pins_type'(~sw);
      ctl <= cp;
      hadr <= ha;
      apb(1'b1, REG_CTRL, {30'h0, r[29:28]}, {33'h1_0000_0000, 33'h0});
      repeat (6) @(posedge clock_in);
      chk(64'(cfg_out), 64'(e));
      cr = e.cpu_ctl_edge ? cp.up_reset : r[28];
      ca = e.cpu_ctl_edge ? cp.up_analyse : r[29];
      herr = cp.cpu_error | (e.slot_ctl_same & cp.slot_error);
      chk(64'(lv_out), 64'({cr, ca, e.slot_ctl_same ? cr : (cp.subsys_reset | (e.reset_copy & cr)),
        e.slot_ctl_same ? ca : cp.subsys_analyse, e.cpu_ctl_edge & herr, !e.slot_ctl_same & cp.slot_error,
        e.host_en & (ha[9:4] == e.host_base[9:4]), cp.host_irq_req & e.irq3, cp.host_irq_req & !e.irq3,
        cp.dma_req & (e.dma == DMA_CH1), cp.dma_req & (e.dma == DMA_CH2)}));
      apb(1'b0, REG_STATUS, 32'h0, {33'h1_ffff_ffff, 30'h0, 1'b1, cr, !e.cpu_ctl_edge & herr});
    end
    apb(1'b0, 12'h00c, 32'h0, {33'h1_ffff_ffff, 1'b1, 32'h0});
    repeat (2) @(posedge clock_in);
    wrap_up();
  end
endmodule

// ### verilog/pbc_config_decoder.sv
// Purpose: static switch decode, control routing and host apb view of the board
// Assumes: switch and control pins asynchronous, mem request on clock_in
// Notes: selects are taken once per reset, then held
`timescale 1ns/1ps
module pbc_config_decoder
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // switch and jumper pins
  input wire pbc_cfg_pins_type cfg_pins_in,
  // control pins
  input wire pbc_ctl_pins_type ctl_pins_in,
  input wire logic [9:0] host_io_addr_in,
  // local memory
  input wire logic mem_req_in,
  input wire logic [23:0] mem_addr_in,
  output logic mem_busy_out,
  output logic mem_done_out,
  output logic [1:0] mem_bank_out,
  output logic [19:0] mem_word_out,
  // decoded configuration
  output pbc_cfg_type cfg_out,
  // control routing
  output logic cpu_reset_out,
  output logic cpu_analyse_out,
  output logic slot_reset_out,
  output logic slot_analyse_out,
  output logic up_error_out,
  output logic subsys_error_out,
  // host side
  output logic host_io_sel_out,
  output logic host_irq3_out,
  output logic host_irq6_out,
  output logic host_dma1_req_out,
  output logic host_dma2_req_out
);
  localparam int SYNC_W = $bits(pbc_cfg_pins_type) + $bits(pbc_ctl_pins_type) + 10;

  pbc_state_type st_r;
  pbc_state_type st_nxt;
  pbc_cfg_pins_type pins_s;
  pbc_ctl_pins_type ctl_s;
  logic [9:0] haddr_s;
  logic [SYNC_W-1:0] sync_q;
  logic mem_busy;
  logic mem_done;
  logic src_reset;
  logic src_analyse;
  logic err_up;
  logic apb_hit;

  pbc_sync2 #(
    .W(SYNC_W)
  ) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .d_in({cfg_pins_in, ctl_pins_in, host_io_addr_in}),
    .q_out(sync_q)
  );

  assign pins_s = sync_q[SYNC_W-1 -: $bits(pbc_cfg_pins_type)];
  assign ctl_s = sync_q[10 +: $bits(pbc_ctl_pins_type)];
  assign haddr_s = sync_q[9:0];

  pbc_mem_timer u_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .start_in(mem_req_in),
    .cycles_in(st_r.cfg.wait_cycles),
    .busy_out(mem_busy),
    .done_out(mem_done)
  );

  always_comb
  begin
    st_nxt = st_r;
    // one-shot sample of the selects
    if (!st_r.loaded)
    begin
      if (st_r.settle == CFG_SETTLE)
      begin
        st_nxt.cfg = pbc_decode(pins_s);
        st_nxt.loaded = 1'b1;
      end
      else
        st_nxt.settle = st_r.settle + 2'h1;
    end
    // processor control source
    src_reset = st_r.cfg.cpu_ctl_edge ? ctl_s.up_reset : st_r.ctrl[CTRL_RESET_BIT];
    src_analyse = st_r.cfg.cpu_ctl_edge ? ctl_s.up_analyse : st_r.ctrl[CTRL_ANALYSE_BIT];
    st_nxt.cpu_reset = src_reset;
    st_nxt.cpu_analyse = src_analyse;
    err_up = ctl_s.cpu_error || (st_r.cfg.slot_ctl_same && ctl_s.slot_error);
    st_nxt.up_error = st_r.cfg.cpu_ctl_edge && err_up;
    st_nxt.host_error = !st_r.cfg.cpu_ctl_edge && err_up;
    // slot control source
    if (st_r.cfg.slot_ctl_same)
    begin
      st_nxt.slot_reset = src_reset;
      st_nxt.slot_analyse = src_analyse;
      st_nxt.subsys_error = 1'b0;
    end
    else
    begin
      st_nxt.slot_reset = ctl_s.subsys_reset || (st_r.cfg.reset_copy && src_reset);
      st_nxt.slot_analyse = ctl_s.subsys_analyse;
      st_nxt.subsys_error = ctl_s.slot_error;
    end
    // host bus decode
    st_nxt.host_io_sel = st_r.cfg.host_en &&
      (haddr_s[9:HOST_WIN_LSB] == st_r.cfg.host_base[9:HOST_WIN_LSB]);
    st_nxt.irq3 = ctl_s.host_irq_req && st_r.cfg.irq3;
    st_nxt.irq6 = ctl_s.host_irq_req && !st_r.cfg.irq3;
    st_nxt.dma1 = ctl_s.dma_req && (st_r.cfg.dma == DMA_CH1);
    st_nxt.dma2 = ctl_s.dma_req && (st_r.cfg.dma == DMA_CH2);
    // memory address split by module size
    if (mem_req_in && !mem_busy)
    begin
      if (st_r.cfg.mem_1mb)
      begin
        st_nxt.mem_bank = mem_addr_in[MEM_BANK_LSB_1M +: 2];
        st_nxt.mem_word = mem_addr_in[MEM_BANK_LSB_1M-1:2];
      end
      else
      begin
        st_nxt.mem_bank = mem_addr_in[MEM_BANK_LSB_256K +: 2];
        st_nxt.mem_word = {2'h0, mem_addr_in[MEM_BANK_LSB_256K-1:2]};
      end
    end
    // apb slave, one wait cycle
    apb_hit = psel_in && penable_in && !st_r.pready;
    st_nxt.pready = apb_hit;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (apb_hit)
    begin
      case (paddr_in)
        REG_CTRL:
          st_nxt.prdata = {30'h0000_0000, st_r.ctrl};
        REG_CFG:
          st_nxt.prdata = st_r.cfg;
        REG_STATUS:
          st_nxt.prdata = {28'h000_0000, mem_busy, st_r.loaded, st_r.cpu_reset, st_r.host_error};
        default:
          st_nxt.pslverr = 1'b1;
      endcase
    end
    // ctrl write lands at the edge after pready shows, which closes the transfer
    if (st_r.pready && psel_in && penable_in && pwrite_in)
    begin
      if ((paddr_in == REG_CTRL) && pstrb_in[0])
        st_nxt.ctrl = pwdata_in[1:0];
    end
    if (!nrst_in)
    begin
      st_nxt = '0;
      st_nxt.cfg = CFG_RST;
      st_nxt.ctrl = CTRL_RST;
      st_nxt.cpu_reset = 1'b1;
      st_nxt.slot_reset = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end

  assign prdata_out = st_r.prdata;
  assign pready_out = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign mem_busy_out = mem_busy;
  assign mem_done_out = mem_done;
  assign mem_bank_out = st_r.mem_bank;
  assign mem_word_out = st_r.mem_word;
  assign cfg_out = st_r.cfg;
  assign cpu_reset_out = st_r.cpu_reset;
  assign cpu_analyse_out = st_r.cpu_analyse;
  assign slot_reset_out = st_r.slot_reset;
  assign slot_analyse_out = st_r.slot_analyse;
  assign up_error_out = st_r.up_error;
  assign subsys_error_out = st_r.subsys_error;
  assign host_io_sel_out = st_r.host_io_sel;
  assign host_irq3_out = st_r.irq3;
  assign host_irq6_out = st_r.irq6;
  assign host_dma1_req_out = st_r.dma1;
  assign host_dma2_req_out = st_r.dma2;

  property p_load_once;
    @(posedge clock_in) disable iff (!nrst_in)
    $rose(nrst_in) |-> !st_r.loaded [*3] ##1 st_r.loaded;
  endproperty
  a_load_once: assert property (p_load_once) else $error("selects not loaded on time");

  property p_cfg_static;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && $past(st_r.loaded)) |-> $stable(cfg_out);
  endproperty
  a_cfg_static: assert property (p_cfg_static) else $error("config changed without reset");

  property p_clk_25;
    @(posedge clock_in) disable iff (!nrst_in)
    ($rose(st_r.loaded) && ($past(pins_s.cpu_clock_link_switch_bank[5:3]) == CLK_SEL_25M))
      |-> (cfg_out.cpu_clk == CLK_25M);
  endproperty
  a_clk_25: assert property (p_clk_25) else $error("clock select decode wrong");

  property p_wait_3;
    @(posedge clock_in) disable iff (!nrst_in)
    (mem_req_in && !mem_busy && (st_r.cfg.wait_cycles == WAIT_CYC_3)) |-> ##3 mem_done;
  endproperty
  a_wait_3: assert property (p_wait_3) else $error("3-cycle access wrong length");

  property p_host_ctl;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && !st_r.cfg.cpu_ctl_edge) |=> (cpu_reset_out == $past(st_r.ctrl[CTRL_RESET_BIT]));
  endproperty
  a_host_ctl: assert property (p_host_ctl) else $error("processor reset not from host");

  property p_slot_same;
    @(posedge clock_in) disable iff (!nrst_in)
    ($past(st_r.loaded) && $past(st_r.cfg.slot_ctl_same)) |-> (slot_reset_out == cpu_reset_out &&
      slot_analyse_out == cpu_analyse_out);
  endproperty
  a_slot_same: assert property (p_slot_same) else $error("slots not following processor source");

  property p_reset_copy;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && !st_r.cfg.slot_ctl_same && st_r.cfg.reset_copy) ##1 cpu_reset_out |-> slot_reset_out;
  endproperty
  a_reset_copy: assert property (p_reset_copy) else $error("processor reset not copied");

  property p_host_off;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && !st_r.cfg.host_en) |=> !host_io_sel_out;
  endproperty
  a_host_off: assert property (p_host_off) else $error("host decode while disabled");

  property p_dma_off;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.cfg.dma == DMA_OFF) |=> (!host_dma1_req_out && !host_dma2_req_out);
  endproperty
  a_dma_off: assert property (p_dma_off) else $error("dma request while disabled");

  property p_irq_route;
    @(posedge clock_in) disable iff (!nrst_in)
    (ctl_s.host_irq_req && st_r.cfg.irq3) |=> (host_irq3_out && !host_irq6_out);
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("interrupt on wrong line");

  property p_link0_rate;
    @(posedge clock_in) disable iff (!nrst_in)
    ($rose(st_r.loaded) && $past(pins_s.cpu_clock_link_switch_bank[SW2_L0])) |->
      (cfg_out.cpu_link0_rate == RATE_10M);
  endproperty
  a_link0_rate: assert property (p_link0_rate) else $error("link 0 rate decode wrong");

  property p_clk_17;
    @(posedge clock_in) disable iff (!nrst_in)
    ($rose(st_r.loaded) && ($past(pins_s.cpu_clock_link_switch_bank[5:3]) == CLK_SEL_17M5))
      |-> (cfg_out.cpu_clk == CLK_17M5);
  endproperty
  a_clk_17: assert property (p_clk_17) else $error("slow clock decode wrong");

  property p_clk_30;
    @(posedge clock_in) disable iff (!nrst_in)
    ($rose(st_r.loaded) && ($past(pins_s.cpu_clock_link_switch_bank[5:3]) == CLK_SEL_30M))
      |-> (cfg_out.cpu_clk == CLK_30M);
  endproperty
  a_clk_30: assert property (p_clk_30) else $error("fast clock decode wrong");

  property p_wait_6;
    @(posedge clock_in) disable iff (!nrst_in)
    (mem_req_in && !mem_busy && (st_r.cfg.wait_cycles == WAIT_CYC_6))
      |-> ##6 mem_done;
  endproperty
  a_wait_6: assert property (p_wait_6) else $error("6-cycle access wrong length");

  property p_busy_min;
    @(posedge clock_in) disable iff (!nrst_in)
    (mem_req_in && !mem_busy)
      |=> mem_busy [*3];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("access too short");

  property p_size_256;
    @(posedge clock_in) disable iff (!nrst_in)
    ($rose(st_r.loaded) && $past(pins_s.module_size_select))
      |-> !cfg_out.mem_1mb;
  endproperty
  a_size_256: assert property (p_size_256) else $error("module size decode wrong");

  property p_edge_ctl;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && st_r.cfg.cpu_ctl_edge)
      |=> (cpu_reset_out == $past(ctl_s.up_reset));
  endproperty
  a_edge_ctl: assert property (p_edge_ctl) else $error("processor reset not from up port");

  property p_subsys_ctl;
    @(posedge clock_in) disable iff (!nrst_in)
    !st_r.cfg.slot_ctl_same |=> (subsys_error_out == $past(ctl_s.slot_error) &&
      slot_analyse_out == $past(ctl_s.subsys_analyse));
  endproperty
  a_subsys_ctl: assert property (p_subsys_ctl) else $error("slots not on subsystem port");

  property p_no_copy;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.loaded && !st_r.cfg.slot_ctl_same && !st_r.cfg.reset_copy)
      |=> (slot_reset_out == $past(ctl_s.subsys_reset));
  endproperty
  a_no_copy: assert property (p_no_copy) else $error("slot reset not independent");

  property p_host_hit;
    @(posedge clock_in) disable iff (!nrst_in)
    (st_r.cfg.host_en && (haddr_s[9:HOST_WIN_LSB] == st_r.cfg.host_base[9:HOST_WIN_LSB]))
      |=> host_io_sel_out;
  endproperty
  a_host_hit: assert property (p_host_hit) else $error("host window missed");

  property p_irq6;
    @(posedge clock_in) disable iff (!nrst_in)
    (ctl_s.host_irq_req && !st_r.cfg.irq3)
      |=> (host_irq6_out && !host_irq3_out);
  endproperty
  a_irq6: assert property (p_irq6) else $error("interrupt not on second line");

  property p_dma2;
    @(posedge clock_in) disable iff (!nrst_in)
    (ctl_s.dma_req && (st_r.cfg.dma == DMA_CH2))
      |=> (host_dma2_req_out && !host_dma1_req_out);
  endproperty
  a_dma2: assert property (p_dma2) else $error("dma request on wrong channel");
endmodule

// ### verilog/pbc_mem_timer.sv
// Purpose: times one local memory access over a set cycle count
// Assumes: cycles_in is 3 to 6 and stable
// Notes: a start while busy is ignored
`timescale 1ns/1ps
module pbc_mem_timer
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // access request
  input wire logic start_in,
  input wire logic [2:0] cycles_in,
  // access state
  output logic busy_out,
  output logic done_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [2:0] count;
  } pbc_timer_state_type;

  pbc_timer_state_type st_r;
  pbc_timer_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy && start_in)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.count = cycles_in - 3'h1;
    end
    else if (st_r.busy)
    begin
      if (st_r.count == 3'h0)
        st_nxt.busy = 1'b0;
      else
      begin
        st_nxt.count = st_r.count - 3'h1;
        st_nxt.done = (st_r.count == 3'h1);
      end
    end
    if (!nrst_in)
      st_nxt = '0;
  end

  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end

  assign busy_out = st_r.busy;
  assign done_out = st_r.done;

  property p_access_len;
    @(posedge clock_in) disable iff (!nrst_in)
    (start_in && !busy_out) |=> busy_out ##[2:5] (done_out && busy_out) ##1 !busy_out;
  endproperty
  a_access_len: assert property (p_access_len) else $error("access length out of range");
endmodule

// ### verilog/pbc_sync2.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: each bit is a slow level
// Notes: only the second stage is read outside
`timescale 1ns/1ps
module pbc_sync2
  import pbc_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pbc_sync_state_type;

  pbc_sync_state_type st_r;
  pbc_sync_state_type st_nxt;

  always_comb
  begin
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
    if (!nrst_in)
      st_nxt = '0;
  end

  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end

  assign q_out = st_r.s2;
endmodule
